// File: tx_port_pkg.sv
package tx_port_pkg;
	// Register offsets; two address LSBs are ignored
	localparam logic [7:0] OFF_IO_POL = 8'h24;
	localparam logic [7:0] OFF_SERVICE = 8'hCC;
	localparam logic [7:0] OFF_LEN_HI = 8'hD0;
	localparam logic [7:0] OFF_LEN_LO = 8'hD4;
	localparam logic [7:0] OFF_CRC_HI = 8'hD8;
	localparam logic [7:0] OFF_CRC_LO = 8'hDC;
	localparam logic [7:0] OFF_PRE_LEN = 8'hE0;
	localparam logic [7:0] OFF_TX_CTRL = 8'hE4;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	// Polarity bits: a one makes the signal active low
	localparam int POL_READY_BIT = 0;
	localparam int POL_ENV_BIT = 1;
	localparam int POL_CLK_BIT = 2;
	// Control register: mode bit and ready lead field
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_LEAD_LSB = 4;
	localparam int CTRL_LEAD_MSB = 7;
	// Timing
	localparam int CLK_MHZ = 40;
	localparam int BIT_PERIOD_NS = 400;
	localparam int SCLK_PERIOD_NS = 200;
	localparam int BIT_HALF_CYCLES = BIT_PERIOD_NS * CLK_MHZ / 2000;
	localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS * CLK_MHZ / 2000;
	localparam logic [2:0] BIT_HALF_LAST = 3'(BIT_HALF_CYCLES - 1);
	localparam logic [1:0] SCLK_HALF_LAST = 2'(SCLK_HALF_CYCLES - 1);
	localparam logic [1:0] TAIL_LAST = 2'h2;
	// Framing
	localparam logic [7:0] HEADER_BITS = 8'h28;
	localparam logic [3:0] ADDR_LAST = 4'h7;
	localparam logic [3:0] FRAME_LAST = 4'hF;
	localparam logic [3:0] READ_LAST = 4'hE;
	localparam logic [3:0] BYTE_LAST = 4'h7;
	localparam logic PREAMBLE_BIT = 1'b1;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	typedef enum logic [2:0] {
		TX_IDLE = 3'h0,
		TX_PREAMBLE = 3'h1,
		TX_HEADER = 3'h3,
		TX_DATA = 3'h2
	} tx_state_type;
	typedef enum logic [1:0] {
		H_IDLE = 2'h0,
		H_WAIT = 2'h1,
		H_SEND = 2'h3,
		H_TAIL = 2'h2
	} host_state_type;
	typedef enum logic [1:0] {
		C_IDLE = 2'h0,
		C_LEAD = 2'h1,
		C_ARM = 2'h3,
		C_SHIFT = 2'h2
	} ctrl_state_type;
endpackage

// File: tx_port_if.sv
`timescale 1ns/1ps
interface tx_port_if;
	logic txBitClock;
	logic txData;
	logic txEnvelope;
	logic txReady;
	logic channelClear;
	logic sclk;
	logic chipSelectN;
	logic addrStrobe;
	logic readNotWrite;
	logic sdHost;
	logic sdHostOe;
	logic sdDev;
	logic sdDevOe;
	logic sdLine;
	// Shared serial data wire, pulled high when nobody drives
	assign sdLine = sdHostOe ? sdHost : (sdDevOe ? sdDev : 1'b1);
	modport device (
		input txData, txEnvelope, sclk, chipSelectN, addrStrobe,
		input readNotWrite, sdLine,
		output txBitClock, txReady, channelClear, sdDev, sdDevOe
	);
	modport host (
		input txBitClock, txReady, channelClear, sdLine,
		output txData, txEnvelope, sclk, chipSelectN, addrStrobe,
		output readNotWrite, sdHost, sdHostOe
	);
endinterface

// File: tx_port_device.sv
`timescale 1ns/1ps
module tx_port_device
	import tx_port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	tx_port_if.device link,
	input wire logic channelEnergyLow,
	output logic modBit,
	output logic modValid,
	output logic txActive
);
	////////////////////////////////////////////////////////////////////////
	// Control port, clocked by the serial control clock
	logic [1:0] rstSclk;
	logic [3:0] cpCnt, next_cpCnt;
	logic [6:0] addrShift, next_addrShift;
	logic [7:0] addrReg, next_addrReg;
	logic [6:0] wrShift, next_wrShift;
	logic readMode, next_readMode;
	logic [7:0] rdShift, next_rdShift;
	logic [7:0] ioPol, next_ioPol;
	logic [7:0] service, next_service;
	logic [7:0] lenHi, next_lenHi;
	logic [7:0] lenLo, next_lenLo;
	logic [7:0] preLen, next_preLen;
	logic [7:0] txCtrl, next_txCtrl;
	logic wrTog, next_wrTog;
	logic [1:0] crcTogSync;
	logic crcSeen, next_crcSeen;
	logic [15:0] crcRead, next_crcRead;
	logic [7:0] addrFull;
	logic [7:0] wordFull;
	// Values crossing from the master clock side
	logic crcTog;
	logic [15:0] crcHold;

	// Read mux; unmapped addresses read as zero
	function automatic logic [7:0] readValue(input logic [7:0] a);
		logic [7:0] v;
		v = READ_UNMAPPED;
		case (a[7:2])
			OFF_IO_POL[7:2]: v = ioPol;
			OFF_SERVICE[7:2]: v = service;
			OFF_LEN_HI[7:2]: v = lenHi;
			OFF_LEN_LO[7:2]: v = lenLo;
			OFF_CRC_HI[7:2]: v = crcRead[15:8];
			OFF_CRC_LO[7:2]: v = crcRead[7:0];
			OFF_PRE_LEN[7:2]: v = preLen;
			OFF_TX_CTRL[7:2]: v = txCtrl;
			default: v = READ_UNMAPPED;
		endcase
		return v;
	endfunction

	logic [3:0] cpRstCnt, next_cpRstCnt;
	logic cpRstN, next_cpRstN;

	// The host holds the serial clock still while in reset, so the control
	// port stays in reset until that clock has carried it in twice
	always_comb
	begin
		next_cpRstCnt = cpRstCnt;
		if (cpRstCnt != FRAME_LAST)
			next_cpRstCnt = cpRstCnt + 4'h1;
		next_cpRstN = cpRstCnt == FRAME_LAST;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			cpRstCnt <= 4'h0;
			cpRstN <= 1'b0;
		end
		else
		begin
			cpRstCnt <= next_cpRstCnt;
			cpRstN <= next_cpRstN;
		end
	end

	// Stretched reset is brought into the serial clock domain
	always_ff @(posedge link.sclk)
	begin
		rstSclk <= {rstSclk[0], cpRstN};
		crcTogSync <= {crcTogSync[0], crcTog};
	end

	assign addrFull = {addrShift, link.sdLine};
	assign wordFull = {wrShift, link.sdLine};

	// Address phase then data phase, sampled on the rising edge
	always_comb
	begin
		next_cpCnt = cpCnt;
		next_addrShift = addrShift;
		next_addrReg = addrReg;
		next_wrShift = wrShift;
		next_readMode = readMode;
		next_rdShift = rdShift;
		next_ioPol = ioPol;
		next_service = service;
		next_lenHi = lenHi;
		next_lenLo = lenLo;
		next_preLen = preLen;
		next_txCtrl = txCtrl;
		next_wrTog = wrTog;
		next_crcSeen = crcSeen;
		next_crcRead = crcRead;
		// CRC snapshot is stable long before its toggle arrives
		if (crcTogSync[1] != crcSeen)
		begin
			next_crcSeen = crcTogSync[1];
			next_crcRead = crcHold;
		end
		if (link.chipSelectN)
			next_cpCnt = 4'h0;
		else if (cpCnt <= ADDR_LAST)
		begin
			// A frame only starts with the address strobe high
			if (cpCnt != 4'h0 || link.addrStrobe)
				next_cpCnt = cpCnt + 4'h1;
			if (cpCnt == 4'h0)
				next_readMode = link.readNotWrite;
			next_addrShift = addrFull[6:0];
			if (cpCnt == ADDR_LAST)
			begin
				next_addrReg = addrFull;
				next_rdShift = readValue(addrFull);
			end
		end
		else
		begin
			next_cpCnt = cpCnt + 4'h1;
			next_rdShift = {rdShift[6:0], 1'b0};
			next_wrShift = wordFull[6:0];
			if (cpCnt == FRAME_LAST && !readMode)
			begin
				// Write commits on the eighth data bit
				next_wrTog = ~wrTog;
				case (addrReg[7:2])
					OFF_IO_POL[7:2]: next_ioPol = wordFull;
					OFF_SERVICE[7:2]: next_service = wordFull;
					OFF_LEN_HI[7:2]: next_lenHi = wordFull;
					OFF_LEN_LO[7:2]: next_lenLo = wordFull;
					OFF_PRE_LEN[7:2]: next_preLen = wordFull;
					OFF_TX_CTRL[7:2]: next_txCtrl = wordFull;
					default: next_wrTog = ~wrTog;
				endcase
			end
		end
	end

	always_ff @(posedge link.sclk)
	begin
		if (!rstSclk[1])
		begin
			cpCnt <= 4'h0;
			addrShift <= 7'h00;
			addrReg <= REG_RESET;
			wrShift <= 7'h00;
			readMode <= 1'b0;
			rdShift <= REG_RESET;
			ioPol <= REG_RESET;
			service <= REG_RESET;
			lenHi <= REG_RESET;
			lenLo <= REG_RESET;
			preLen <= REG_RESET;
			txCtrl <= REG_RESET;
			wrTog <= 1'b0;
			crcSeen <= 1'b0;
			crcRead <= 16'h0000;
		end
		else
		begin
			cpCnt <= next_cpCnt;
			addrShift <= next_addrShift;
			addrReg <= next_addrReg;
			wrShift <= next_wrShift;
			readMode <= next_readMode;
			rdShift <= next_rdShift;
			ioPol <= next_ioPol;
			service <= next_service;
			lenHi <= next_lenHi;
			lenLo <= next_lenLo;
			preLen <= next_preLen;
			txCtrl <= next_txCtrl;
			wrTog <= next_wrTog;
			crcSeen <= next_crcSeen;
			crcRead <= next_crcRead;
		end
	end

	// Device drives the data phase of a read, MSB first
	assign link.sdDev = rdShift[7];
	assign link.sdDevOe = !link.chipSelectN && readMode && cpCnt > ADDR_LAST;

	////////////////////////////////////////////////////////////////////////
	// Transmit side on the master clock, independent of the control port
	logic [1:0] envSync, dataSync, wrTogSync;
	logic wrSeen;
	logic [7:0] polCfg, serviceCfg, preLenCfg, ctrlCfg;
	logic [15:0] lenCfg;
	logic chanReg;
	logic envActive, modeInternal, fallEv;
	logic [7:0] leadBits;
	tx_state_type state, next_state;
	logic [2:0] divCnt, next_divCnt;
	logic clkPhase, next_clkPhase;
	logic [7:0] bitCnt, next_bitCnt;
	logic [39:0] hdrShift, next_hdrShift;
	logic readyOut, next_readyOut;
	logic next_modBit, next_modValid;
	logic next_crcTog;
	logic [15:0] next_crcHold;

	// Header check over service and length, LSB first
	function automatic logic [15:0] crc16(input logic [23:0] d);
		logic [15:0] c;
		logic fb;
		c = CRC_INIT;
		fb = 1'b0;
		for (int i = 0; i < 24; i++)
		begin
			fb = c[15] ^ d[i];
			c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
		end
		return c;
	endfunction

	// Envelope, data and the write toggle pass two flops, channel energy one; config copies on toggle
	always_ff @(posedge ref_clk)
	begin
		envSync <= {envSync[0], link.txEnvelope};
		dataSync <= {dataSync[0], link.txData};
		wrTogSync <= {wrTogSync[0], wrTog};
		chanReg <= channelEnergyLow;
		if (!rst_n)
		begin
			wrSeen <= 1'b0;
			polCfg <= REG_RESET;
			serviceCfg <= REG_RESET;
			lenCfg <= 16'h0000;
			preLenCfg <= REG_RESET;
			ctrlCfg <= REG_RESET;
		end
		else if (wrTogSync[1] != wrSeen)
		begin
			wrSeen <= wrTogSync[1];
			polCfg <= ioPol;
			serviceCfg <= service;
			lenCfg <= {lenHi, lenLo};
			preLenCfg <= preLen;
			ctrlCfg <= txCtrl;
		end
	end

	assign envActive = envSync[1] ^ polCfg[POL_ENV_BIT];
	assign modeInternal = ctrlCfg[CTRL_MODE_BIT];
	assign leadBits = {4'h0, ctrlCfg[CTRL_LEAD_MSB:CTRL_LEAD_LSB]};
	assign fallEv = (state != TX_IDLE) && clkPhase &&
		(divCnt == BIT_HALF_LAST);

	// Bit clock divider and framing sequencer
	always_comb
	begin
		next_state = state;
		next_divCnt = divCnt;
		next_clkPhase = clkPhase;
		next_bitCnt = bitCnt;
		next_hdrShift = hdrShift;
		next_readyOut = readyOut;
		next_modBit = modBit;
		next_modValid = 1'b0;
		next_crcTog = crcTog;
		next_crcHold = crcHold;
		if (state != TX_IDLE)
		begin
			next_divCnt = divCnt + 3'h1;
			if (divCnt == BIT_HALF_LAST)
			begin
				next_divCnt = 3'h0;
				next_clkPhase = ~clkPhase;
			end
		end
		case (state)
			TX_IDLE:
				// Channel clear plays no part in starting
				if (envActive)
				begin
					next_clkPhase = 1'b1;
					next_divCnt = 3'h0;
					next_crcHold = crc16({lenCfg, serviceCfg});
					next_crcTog = ~crcTog;
					next_hdrShift = {next_crcHold, lenCfg, serviceCfg};
					next_bitCnt = preLenCfg;
					if (!modeInternal)
						next_state = TX_DATA;
					else if (preLenCfg == 8'h00)
					begin
						next_state = TX_HEADER;
						next_bitCnt = HEADER_BITS;
					end
					else
						next_state = TX_PREAMBLE;
				end
			TX_PREAMBLE:
				if (fallEv)
				begin
					next_modValid = 1'b1;
					next_modBit = PREAMBLE_BIT;
					next_bitCnt = bitCnt - 8'h01;
					if (bitCnt == 8'h01)
					begin
						next_state = TX_HEADER;
						next_bitCnt = HEADER_BITS;
					end
				end
			TX_HEADER:
			begin
				// Early notice when few header bits remain
				if (bitCnt <= leadBits)
					next_readyOut = 1'b1;
				if (fallEv)
				begin
					next_modValid = 1'b1;
					next_modBit = hdrShift[0];
					next_hdrShift = {1'b0, hdrShift[39:1]};
					next_bitCnt = bitCnt - 8'h01;
					if (bitCnt == 8'h01)
					begin
						next_state = TX_DATA;
						next_readyOut = 1'b1;
					end
				end
			end
			TX_DATA:
				// Each bit goes straight to the modulator
				if (fallEv)
				begin
					next_modValid = 1'b1;
					next_modBit = dataSync[1];
				end
			default:
				next_state = TX_IDLE;
		endcase
		if (state != TX_IDLE && !envActive)
		begin
			next_state = TX_IDLE;
			next_clkPhase = 1'b0;
			next_divCnt = 3'h0;
			next_readyOut = 1'b0;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			state <= TX_IDLE;
			divCnt <= 3'h0;
			clkPhase <= 1'b0;
			bitCnt <= 8'h00;
			hdrShift <= 40'h0000000000;
			readyOut <= 1'b0;
			modBit <= 1'b0;
			modValid <= 1'b0;
			crcTog <= 1'b0;
			crcHold <= 16'h0000;
		end
		else
		begin
			state <= next_state;
			divCnt <= next_divCnt;
			clkPhase <= next_clkPhase;
			bitCnt <= next_bitCnt;
			hdrShift <= next_hdrShift;
			readyOut <= next_readyOut;
			modBit <= next_modBit;
			modValid <= next_modValid;
			crcTog <= next_crcTog;
			crcHold <= next_crcHold;
		end
	end

	// Pin polarity applied last; ready stays low in external mode
	assign link.txBitClock = clkPhase ^ polCfg[POL_CLK_BIT];
	assign link.txReady = modeInternal ?
		(readyOut ^ polCfg[POL_READY_BIT]) : 1'b0;
	assign link.channelClear = chanReg;
	assign txActive = state != TX_IDLE;
endmodule

// File: tx_port_host.sv
`timescale 1ns/1ps
module tx_port_host
	import tx_port_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	tx_port_if.host link,
	input wire logic clkActiveLow,
	input wire logic envActiveLow,
	input wire logic readyActiveLow,
	input wire logic internalPreamble,
	input wire logic [3:0] readyLead,
	input wire logic txRequest,
	input wire logic [7:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic txBusy,
	output logic channelClearSeen,
	input wire logic cfgReq,
	input wire logic cfgRead,
	input wire logic [7:0] cfgAddr,
	input wire logic [7:0] cfgWData,
	output logic cfgBusy,
	output logic cfgDone,
	output logic [7:0] cfgRData
);
	////////////////////////////////////////////////////////////////////////
	// Device pins pass two flops before use
	logic [1:0] clkSync, readySync, chanSync, sdSync;
	logic clkPrev;
	logic clkAct, readyAct, rise;

	always_ff @(posedge ref_clk)
	begin
		clkSync <= {clkSync[0], link.txBitClock};
		readySync <= {readySync[0], link.txReady};
		chanSync <= {chanSync[0], link.channelClear};
		sdSync <= {sdSync[0], link.sdLine};
		clkPrev <= rst_n ? clkAct : 1'b0;
	end

	assign clkAct = clkSync[1] ^ clkActiveLow;
	assign readyAct = readySync[1] ^ readyActiveLow;
	assign rise = clkAct && !clkPrev;
	assign channelClearSeen = chanSync[1];

	////////////////////////////////////////////////////////////////////////
	// Two-entry buffer: a slow link stalls the byte source
	logic [7:0] mem [0:1];
	logic [7:0] next_mem [0:1];
	logic wrPtr, next_wrPtr, rdPtr, next_rdPtr;
	logic [1:0] fill, next_fill;
	logic push, pop;

	assign inReady = fill != 2'h2;
	assign push = inValid && inReady;

	always_comb
	begin
		next_mem = mem;
		next_wrPtr = wrPtr;
		next_rdPtr = rdPtr;
		next_fill = fill;
		if (push)
		begin
			next_mem[wrPtr] = inData;
			next_wrPtr = ~wrPtr;
		end
		if (pop)
			next_rdPtr = ~rdPtr;
		next_fill = fill + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge ref_clk)
	begin
		mem <= next_mem;
		wrPtr <= rst_n ? next_wrPtr : 1'b0;
		rdPtr <= rst_n ? next_rdPtr : 1'b0;
		fill <= rst_n ? next_fill : 2'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// Envelope and serialiser, driving on the bit clock rising edge
	host_state_type hState, next_hState;
	logic envOn, next_envOn, dataOut, next_dataOut;
	logic [7:0] shift, next_shift;
	logic [3:0] bitsLeft, next_bitsLeft, skip, next_skip;
	logic [1:0] tailCnt, next_tailCnt;

	always_comb
	begin
		next_hState = hState;
		next_envOn = envOn;
		next_dataOut = dataOut;
		next_shift = shift;
		next_bitsLeft = bitsLeft;
		next_skip = skip;
		next_tailCnt = tailCnt;
		pop = 1'b0;
		case (hState)
			H_IDLE:
				if (txRequest)
				begin
					next_envOn = 1'b1;
					next_skip = internalPreamble ? readyLead : 4'h0;
					next_hState = internalPreamble ? H_WAIT : H_SEND;
				end
			H_WAIT:
				if (readyAct)
					next_hState = H_SEND;
			H_SEND:
				if (rise && skip != 4'h0)
					next_skip = skip - 4'h1;
				else if (rise)
				begin
					if (bitsLeft != 4'h0)
					begin
						next_dataOut = shift[0];
						next_shift = {1'b0, shift[7:1]};
						next_bitsLeft = bitsLeft - 4'h1;
					end
					else if (fill != 2'h0)
					begin
						pop = 1'b1;
						next_dataOut = mem[rdPtr][0];
						next_shift = {1'b0, mem[rdPtr][7:1]};
						next_bitsLeft = BYTE_LAST;
					end
					else
					begin
						next_dataOut = 1'b0;
						if (!txRequest)
						begin
							next_hState = H_TAIL;
							next_tailCnt = 2'h0;
						end
					end
				end
			H_TAIL:
				// Keep the envelope up while the last bits modulate
				if (rise)
				begin
					next_tailCnt = tailCnt + 2'h1;
					if (tailCnt == TAIL_LAST)
					begin
						next_envOn = 1'b0;
						next_hState = H_IDLE;
					end
				end
			default:
				next_hState = H_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			hState <= H_IDLE;
			envOn <= 1'b0;
			dataOut <= 1'b0;
			shift <= 8'h00;
			bitsLeft <= 4'h0;
			skip <= 4'h0;
			tailCnt <= 2'h0;
		end
		else
		begin
			hState <= next_hState;
			envOn <= next_envOn;
			dataOut <= next_dataOut;
			shift <= next_shift;
			bitsLeft <= next_bitsLeft;
			skip <= next_skip;
			tailCnt <= next_tailCnt;
		end
	end

	assign link.txEnvelope = envOn ^ envActiveLow;
	assign link.txData = dataOut;
	assign txBusy = hState != H_IDLE;

	////////////////////////////////////////////////////////////////////////
	// Control port master; the serial clock runs freely from reset
	ctrl_state_type cState, next_cState;
	logic [1:0] sDiv, next_sDiv;
	logic sclk, next_sclk, csN, next_csN, as, next_as;
	logic rwReg, next_rwReg, hostOe, next_hostOe, next_cfgDone;
	logic [15:0] frame, next_frame;
	logic [3:0] bitIdx, next_bitIdx;
	logic [7:0] next_cfgRData;
	logic sRise, sFall;

	assign sRise = !sclk && sDiv == SCLK_HALF_LAST;
	assign sFall = sclk && sDiv == SCLK_HALF_LAST;

	always_comb
	begin
		next_cState = cState;
		next_sDiv = (sDiv == SCLK_HALF_LAST) ? 2'h0 : sDiv + 2'h1;
		next_sclk = (sDiv == SCLK_HALF_LAST) ? ~sclk : sclk;
		next_csN = csN;
		next_as = as;
		next_rwReg = rwReg;
		next_hostOe = hostOe;
		next_frame = frame;
		next_bitIdx = bitIdx;
		next_cfgRData = cfgRData;
		next_cfgDone = 1'b0;
		case (cState)
			C_IDLE:
				if (cfgReq)
				begin
					next_frame = {cfgAddr, cfgWData};
					next_rwReg = cfgRead;
					next_cState = C_LEAD;
				end
			C_LEAD:
				// One rising edge with select high before each access
				if (sRise)
					next_cState = C_ARM;
			C_ARM:
				if (sFall)
				begin
					next_csN = 1'b0;
					next_as = 1'b1;
					next_hostOe = 1'b1;
					next_bitIdx = 4'h0;
					next_cState = C_SHIFT;
				end
			C_SHIFT:
			begin
				// Let go of the wire as the device takes it
				if (sRise && rwReg && bitIdx == ADDR_LAST)
					next_hostOe = 1'b0;
				if (sFall)
				begin
					if (rwReg && bitIdx >= ADDR_LAST && bitIdx <= READ_LAST)
						next_cfgRData = {cfgRData[6:0], sdSync[1]};
					if (bitIdx == FRAME_LAST)
					begin
						next_csN = 1'b1;
						next_hostOe = 1'b0;
						next_cfgDone = 1'b1;
						next_cState = C_IDLE;
					end
					else
					begin
						next_bitIdx = bitIdx + 4'h1;
						next_frame = {frame[14:0], 1'b0};
						if (bitIdx == ADDR_LAST)
							next_as = 1'b0;
					end
				end
			end
			default:
				next_cState = C_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			cState <= C_IDLE;
			sDiv <= 2'h0;
			sclk <= 1'b0;
			csN <= 1'b1;
			as <= 1'b0;
			rwReg <= 1'b0;
			hostOe <= 1'b0;
			frame <= 16'h0000;
			bitIdx <= 4'h0;
			cfgRData <= 8'h00;
			cfgDone <= 1'b0;
		end
		else
		begin
			cState <= next_cState;
			sDiv <= next_sDiv;
			sclk <= next_sclk;
			csN <= next_csN;
			as <= next_as;
			rwReg <= next_rwReg;
			hostOe <= next_hostOe;
			frame <= next_frame;
			bitIdx <= next_bitIdx;
			cfgRData <= next_cfgRData;
			cfgDone <= next_cfgDone;
		end
	end

	assign link.sclk = sclk;
	assign link.chipSelectN = csN;
	assign link.addrStrobe = as;
	assign link.readNotWrite = rwReg;
	assign link.sdHost = frame[15];
	assign link.sdHostOe = hostOe;
	assign cfgBusy = cState != C_IDLE;
endmodule

// File: tx_port_props.sv
`timescale 1ns/1ps
module tx_port_props
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic txBitClock,
	input wire logic txData,
	input wire logic txEnvelope,
	input wire logic txReady,
	input wire logic chipSelectN,
	input wire logic addrStrobe
);
	logic [7:0] asCount, csCount, next_asCount, next_csCount;
	// Cycles spent in the address and select windows
	always_comb
	begin
		next_asCount = addrStrobe ? asCount + 8'h01 : 8'h00;
		next_csCount = chipSelectN ? 8'h00 : csCount + 8'h01;
	end
	// Registers only; reset empties both windows
	always_ff @(posedge ref_clk)
	begin
		asCount <= rst_n ? next_asCount : 8'h00;
		csCount <= rst_n ? next_csCount : 8'h00;
	end
	////////////////////////////////////////////////////////////
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Envelope sync costs two cycles, so allow four before idle
	AST_IDLE_CLK: assert property (
		!txEnvelope [*4] |-> !txBitClock)
		else $error("clock without envelope");
	AST_CLK_START: assert property (
		$rose(txEnvelope) |-> ##[2:4] txBitClock)
		else $error("clock start late");
	AST_CLK_LOW: assert property (
		$fell(txBitClock) |-> !txBitClock [*8])
		else $error("low phase short");
	AST_CLK_HIGH: assert property (
		$rose(txBitClock) ##1 txEnvelope [*7] |-> txBitClock)
		else $error("high phase short");
	// Data settles well before the capturing edge
	AST_DATA_HOLD: assert property (
		$fell(txBitClock) && txEnvelope |-> txData == $past(txData, 3)
		&& $stable(txData)) else $error("data moved near capture");
	// Control frame: 8 address bits, 16 bits in all
	AST_ADDR_LEN: assert property (
		$fell(addrStrobe) |-> asCount == 8'h40)
		else $error("address phase length");
	AST_CS_LEN: assert property (
		$rose(chipSelectN) |-> csCount == 8'h80)
		else $error("select length");
	AST_CS_START: assert property (
		$fell(chipSelectN) |-> addrStrobe)
		else $error("frame lacks address");
	AST_READY_IDLE: assert property (
		!txEnvelope [*5] |-> !txReady)
		else $error("ready outside frame");
	cover property ($rose(txReady));
	cover property ($fell(addrStrobe));
	cover property ($fell(txBitClock));
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench
	import tx_port_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic channelEnergyLow = 1'b0;
	logic internalPreamble = 1'b0;
	logic txRequest = 1'b0;
	logic inValid = 1'b0;
	logic cfgReq = 1'b0;
	logic cfgRead = 1'b0;
	logic [3:0] readyLead = 4'h0;
	logic [7:0] inData = 8'h00;
	logic [7:0] cfgAddr = 8'h00;
	logic [7:0] cfgWData = 8'h00;
	logic modBit, modValid, inReady, txBusy, txActive;
	logic channelClearSeen, cfgBusy, cfgDone;
	logic [7:0] cfgRData, v;
	logic [39:0] hdr;
	logic [7:0] offs [8] = '{OFF_IO_POL, OFF_SERVICE, OFF_LEN_HI,
		OFF_LEN_LO, OFF_CRC_HI, OFF_CRC_LO, OFF_PRE_LEN, OFF_TX_CTRL};
	logic expBits [$];
	logic [7:0] expData [$];
	int errors = 0;
	int n_compared = 0;
	int seed = 46401;
	int nBits = 0;
	int readyAt = -1;
	// Reference clock, 25 ns
	always #12.5 ref_clk = ~ref_clk;
	// Both ends face each other across the link
	tx_port_if link ();
	tx_port_device tx_port_device_i (.ref_clk, .rst_n, .link,
		.channelEnergyLow, .modBit, .modValid, .txActive);
	tx_port_host tx_port_host_i (.ref_clk, .rst_n, .link,
		.clkActiveLow(1'b0), .envActiveLow(1'b0), .readyActiveLow(1'b0),
		.internalPreamble, .readyLead, .txRequest, .inData, .inValid,
		.inReady, .txBusy, .channelClearSeen, .cfgReq, .cfgRead,
		.cfgAddr, .cfgWData, .cfgBusy, .cfgDone, .cfgRData);
	tx_port_props tx_port_props_i (.ref_clk, .rst_n,
		.txBitClock(link.txBitClock), .txData(link.txData),
		.txEnvelope(link.txEnvelope), .txReady(link.txReady),
		.chipSelectN(link.chipSelectN), .addrStrobe(link.addrStrobe));
	////////////////////////////////////////////////////////////
	task automatic check(input logic [7:0] got, want);
		n_compared++;
		if (got !== want)
		begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic wrap_up();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// One control access; a read queues d as its expected data
	task automatic cfg(input logic rd, input logic [7:0] a, d);
		int n;
		n = 0;
		while (cfgBusy !== 1'b0)
			@(posedge ref_clk);
		if (rd)
			expData.push_back(d);
		cfgReq <= 1'b1;
		cfgRead <= rd;
		cfgAddr <= a;
		cfgWData <= d;
		@(posedge ref_clk);
		cfgReq <= 1'b0;
		while (cfgDone !== 1'b1 && n < 400)
		begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 400)
		begin
			errors++;
			$display("unexpected at %0t: control access timeout", $time);
		end
	endtask
	// Four bytes; two fill the buffer before the frame is requested
	task automatic frame();
		logic [7:0] b;
		int n;
		nBits = 0;
		readyAt = -1;
		for (int i = 0; i < 4; i++)
		begin
			b = 8'($random(seed));
			for (int k = 0; k < 8; k++)
				expBits.push_back(b[k]);
			inData <= b;
			inValid <= 1'b1;
			if (i == 2)
			begin
				@(posedge ref_clk);
				check(8'(inReady), 8'h00);
				txRequest <= 1'b1;
			end
			do
				@(posedge ref_clk);
			while (inReady !== 1'b1);
		end
		inValid <= 1'b0;
		txRequest <= 1'b0;
		n = 0;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (txBusy !== 1'b0 && n < 4000);
		if (n >= 4000)
		begin
			errors++;
			$display("unexpected at %0t: frame timeout", $time);
		end
		check(8'(expBits.size()), 8'h00);
	endtask
	// Compare each result with the oldest note as it appears
	always @(posedge ref_clk)
	begin
		if (modValid === 1'b1)
		begin
			nBits++;
			check(8'(txActive), 8'h01);
			if (expBits.size() > 0)
				check(8'(modBit), 8'(expBits.pop_front()));
		end
		if (txReady_seen())
			readyAt = nBits;
		if (cfgDone === 1'b1 && cfgRead === 1'b1 && expData.size() > 0)
			check(cfgRData, expData.pop_front());
	end
	function automatic logic txReady_seen();
		return link.txReady === 1'b1 && readyAt < 0;
	endfunction
	// Main sequence
	initial
	begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (40) @(posedge ref_clk);
		foreach (offs[i])
			cfg(1'b1, offs[i], REG_RESET);
		cfg(1'b1, 8'h40, READ_UNMAPPED);
		// Read back through ignored address LSBs; CRC stays read-only
		for (int i = 1; i < 7; i++)
		begin
			v = 8'($random(seed));
			cfg(1'b0, offs[i], v);
			cfg(1'b1, offs[i] | 8'h03, i inside {4, 5} ? REG_RESET : v);
		end
		// A busy channel must not hold back an external frame
		channelEnergyLow <= 1'b1;
		repeat (8) @(posedge ref_clk);
		check(8'(channelClearSeen), 8'h01);
		channelEnergyLow <= 1'b0;
		frame();
		check(8'(readyAt < 0), 8'h01);
		// Internal preamble of 8 bits, header, ready three bits early
		hdr[23:0] = 24'($random(seed));
		cfg(1'b0, OFF_SERVICE, hdr[7:0]);
		cfg(1'b0, OFF_LEN_LO, hdr[15:8]);
		cfg(1'b0, OFF_LEN_HI, hdr[23:16]);
		cfg(1'b0, OFF_PRE_LEN, 8'h08);
		cfg(1'b0, OFF_TX_CTRL, 8'h31);
		internalPreamble <= 1'b1;
		readyLead <= 4'h3;
		hdr[39:24] = CRC_INIT;
		for (int i = 0; i < 24; i++)
			hdr[39:24] = {hdr[38:24], 1'b0}
				^ ((hdr[39] ^ hdr[i]) ? CRC_POLY : 16'h0000);
		repeat (8)
			expBits.push_back(PREAMBLE_BIT);
		for (int i = 0; i < 40; i++)
			expBits.push_back(hdr[i]);
		fork
			frame();
			begin
				repeat (600) @(posedge ref_clk);
				cfg(1'b1, OFF_CRC_LO, hdr[31:24]);
			end
		join
		check(8'(readyAt inside {[44:46]}), 8'h01);
		check(8'(expData.size()), 8'h00);
		wrap_up();
	end
	// Cut a hang short
	initial
	begin
		#2000000;
		errors++;
		$display("unexpected at %0t: timeout", $time);
		wrap_up();
	end
endmodule
